// *** nsr_consts.svh ***
// Constants of the status and option register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef NSR_CONSTS_SVH
`define NSR_CONSTS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define NSR_A_COLL_HI   5'h0d
`define NSR_A_COLL      5'h0e
`define NSR_A_STRENGTH  5'h0f
`define NSR_A_OPTIONS   5'h10
`define NSR_A_IRQ_STAT  5'h1c
`define NSR_A_IRQ_MASK  5'h1d
// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define NSR_RST_BYTE    8'h00
`define NSR_OPT_MASK    8'h3f
`define NSR_IRQ_MASK_W  8'h07
`define NSR_IRQ_POSN    0
`define NSR_IRQ_PULSE   1
`define NSR_IRQ_OSC     2
`define NSR_OPT_PAR     5
`define NSR_OPT_SLOT    4
`define NSR_OPT_BITSTR  3
`define NSR_OPT_FOURB   2
`define NSR_OPT_NORMF   1
`define NSR_OPT_SIX     0
// ---------------------------------------------------------------
// Timing and counts
// ---------------------------------------------------------------
`define NSR_CLK_MHZ     25
`define NSR_OSC_US      200
`define NSR_PULSE_SEVEN 4'h7
`define NSR_PULSE_SIX   4'h6
`define NSR_PULSE_SAT   4'hf
`endif

// *** nsr_pkg.sv ***
// Types shared by the status and option register bank.
// Assumes nothing beyond the constants header.
`include "nsr_consts.svh"
package nsr_pkg;
   // Oscillator settling states.
   typedef enum logic [1:0] {
      NSR_OSC_OFF  = 2'b00,
      NSR_OSC_WAIT = 2'b01,
      NSR_OSC_OK   = 2'b10
   } nsr_osc_e;
   typedef logic [7:0] nsr_byte_t;
endpackage

// *** nsr_bank.sv ***
// Collision position, signal strength and option registers.
// Assumes receive datapath signals share clk_sys; pins are synchronised.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "nsr_consts.svh"
module nsr_bank #(
   parameter int OSC_CYC = `NSR_OSC_US * `NSR_CLK_MHZ
) (
   input  wire logic       clk_sys,       // System clock, 25 MHz.
   input  wire logic       reset_n,       // Asynchronous reset.
   input  wire logic       enable_pin,    // Enable pin, asynchronous.
   input  wire logic       osc_run_pin,   // Oscillator running, async.
   input  wire logic [4:0] addr,          // Register address.
   input  wire logic [7:0] wdata,         // Write data.
   input  wire logic       wr,            // Write strobe.
   input  wire logic       rd,            // Read strobe.
   output logic      [7:0] rdata,         // Read data, cycle after rd.
   output logic            irq,           // Level interrupt.
   input  wire logic       pos_event,     // Position capture pulse.
   input  wire logic [9:0] pos_in,        // Bit position of event.
   input  wire logic       typea_mode,    // Type A protocol active.
   input  wire logic       rx_active,     // Reception in progress.
   input  wire logic       tx_start,      // Reader transmit begins.
   input  wire logic       swap_inputs,   // Swap receive inputs.
   input  wire logic       amp_meas,      // Amplitude command active.
   input  wire logic [2:0] env_one,       // Envelope code, input one.
   input  wire logic [2:0] env_two,       // Envelope code, input two.
   input  wire logic [2:0] car_one,       // Carrier code, input one.
   input  wire logic [2:0] car_two,       // Carrier code, input two.
   input  wire logic       sub_pulse,     // Subcarrier pulse seen.
   input  wire logic       bit_end,       // Bit period boundary.
   output logic            coll_detect,   // Pulse threshold exceeded.
   output logic            typea_parity_disable, // Skip parity.
   output logic            slot_grid_long,       // 37.77 us grid.
   output logic            typea_bitstream_tx,   // Direct transmit.
   output logic            four_bit_rx,          // 4-bit replies.
   output logic            normal_framing,       // No broken bytes.
   output logic            six_pulse_sel         // Six pulse limit.
);
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (OSC_CYC < 1 || OSC_CYC > 65535) begin : g_bad
      $error("OSC_CYC out of range");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] en_s;
   logic [2:0] osc_s;
   logic       en_q;
   logic       osc_q;
   logic       next_en_q;
   logic       next_osc_q;

   // A change is taken only once the second and third stages agree.
   always_comb begin
      next_en_q  = (en_s[1] == en_s[2]) ? en_s[2] : en_q;
      next_osc_q = (osc_s[1] == osc_s[2]) ? osc_s[2] : osc_q;
   end

   // Shift the pins in; the first stage feeds only the second.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         en_s  <= 3'h0;
         osc_s <= 3'h0;
         en_q  <= 1'b0;
         osc_q <= 1'b0;
      end else begin
         en_s  <= {en_s[1:0], enable_pin};
         osc_s <= {osc_s[1:0], osc_run_pin};
         en_q  <= next_en_q;
         osc_q <= next_osc_q;
      end
   end

   // Enable low acts as a clocked clear of every register except rdata, osc_ok_d and the pin synchronisers.
   logic clr;
   assign clr = !en_q;

   // Address match helpers.
   function automatic logic hit(input logic s, input logic [4:0] a,
                                input logic [4:0] o);
      hit = s && (a == o);
   endfunction

   // ---------------------------------------------------------------
   // Collision position
   // ---------------------------------------------------------------
   logic [9:0] coll_pos;
   logic [9:0] next_coll_pos;

   // A capture in the same cycle as a clearing read wins.
   always_comb begin
      next_coll_pos = coll_pos;
      if (hit(rd, addr, `NSR_A_COLL))
         next_coll_pos = 10'h000;
      if (pos_event) begin
         next_coll_pos[7:0] = pos_in[7:0];
         next_coll_pos[9:8] = typea_mode ? pos_in[9:8] : 2'h0;
      end
      if (clr)
         next_coll_pos = 10'h000;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         coll_pos <= 10'h000;
      else
         coll_pos <= next_coll_pos;
   end

   // ---------------------------------------------------------------
   // Oscillator settling
   // ---------------------------------------------------------------
   nsr_pkg::nsr_osc_e osc_st;
   nsr_pkg::nsr_osc_e next_osc_st;
   logic [15:0]       osc_cnt;
   logic [15:0]       next_osc_cnt;

   // Counting from the start keeps the ready flag off while settling.
   always_comb begin
      next_osc_st  = osc_st;
      next_osc_cnt = osc_cnt;
      unique case (osc_st)
         nsr_pkg::NSR_OSC_OFF: begin
            next_osc_cnt = 16'h0000;
            if (osc_q)
               next_osc_st = nsr_pkg::NSR_OSC_WAIT;
         end
         nsr_pkg::NSR_OSC_WAIT: begin
            next_osc_cnt = osc_cnt + 16'h0001;
            if (osc_cnt == 16'(OSC_CYC - 1))
               next_osc_st = nsr_pkg::NSR_OSC_OK;
         end
         nsr_pkg::NSR_OSC_OK: begin
            next_osc_cnt = 16'h0000;
         end
         default: begin
            next_osc_st = nsr_pkg::NSR_OSC_OFF;
         end
      endcase
      if (!osc_q || clr) begin
         next_osc_st  = nsr_pkg::NSR_OSC_OFF;
         next_osc_cnt = 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         osc_st  <= nsr_pkg::NSR_OSC_OFF;
         osc_cnt <= 16'h0000;
      end else begin
         osc_st  <= next_osc_st;
         osc_cnt <= next_osc_cnt;
      end
   end

   logic osc_ok;
   assign osc_ok = (osc_st == nsr_pkg::NSR_OSC_OK);

   // ---------------------------------------------------------------
   // Signal strength peak hold
   // ---------------------------------------------------------------
   logic [2:0] main_pk;
   logic [2:0] aux_pk;
   logic [2:0] next_main_pk;
   logic [2:0] next_aux_pk;
   logic [2:0] src_one;
   logic [2:0] src_two;
   logic [2:0] main_src;
   logic [2:0] aux_src;

   // Codes are 3-bit 4 dB steps, so peak compare is plain magnitude.
   always_comb begin
      src_one  = amp_meas ? car_one : env_one;
      src_two  = amp_meas ? car_two : env_two;
      main_src = swap_inputs ? src_two : src_one;
      aux_src  = swap_inputs ? src_one : src_two;
      next_main_pk = main_pk;
      next_aux_pk  = aux_pk;
      if (rx_active || amp_meas) begin
         if (main_src > main_pk)
            next_main_pk = main_src;
         if (aux_src > aux_pk)
            next_aux_pk = aux_src;
      end
      if (tx_start || clr) begin
         next_main_pk = 3'h0;
         next_aux_pk  = 3'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         main_pk <= 3'h0;
         aux_pk  <= 3'h0;
      end else begin
         main_pk <= next_main_pk;
         aux_pk  <= next_aux_pk;
      end
   end

   // ---------------------------------------------------------------
   // Options, pulse counter, interrupt registers
   // ---------------------------------------------------------------
   logic [7:0] opts;
   logic [7:0] next_opts;
   logic [3:0] pcnt;
   logic [3:0] next_pcnt;
   logic [3:0] plim;
   logic       next_coll_detect;
   logic [2:0] ist;
   logic [2:0] next_ist;
   logic [2:0] imask;
   logic [2:0] next_imask;
   logic       osc_ok_d;
   logic [2:0] iset;
   logic [7:0] next_rdata;

   // Status bits are sticky; a set in the clearing read's cycle survives.
   always_comb begin
      next_opts  = opts;
      next_imask = imask;
      if (hit(wr, addr, `NSR_A_OPTIONS))
         next_opts = wdata & `NSR_OPT_MASK;
      if (hit(wr, addr, `NSR_A_IRQ_MASK))
         next_imask = wdata[2:0];
      plim = opts[`NSR_OPT_SIX] ? `NSR_PULSE_SIX
                                : `NSR_PULSE_SEVEN;
      next_pcnt = (sub_pulse && pcnt != `NSR_PULSE_SAT)
                  ? pcnt + 4'h1 : pcnt;
      next_coll_detect = next_pcnt > plim;
      if (bit_end)
         next_pcnt = 4'h0;
      iset = 3'h0;
      iset[`NSR_IRQ_POSN]  = pos_event;
      iset[`NSR_IRQ_PULSE] = next_coll_detect && !coll_detect;
      iset[`NSR_IRQ_OSC]   = osc_ok && !osc_ok_d;
      next_ist = ist;
      if (hit(rd, addr, `NSR_A_IRQ_STAT))
         next_ist = 3'h0;
      next_ist = next_ist | iset;
      if (clr) begin
         next_opts        = `NSR_RST_BYTE;
         next_imask       = 3'h0;
         next_ist         = 3'h0;
         next_pcnt        = 4'h0;
         next_coll_detect = 1'b0;
      end
   end

   // Read mux; unmapped addresses and reserved bits read zero.
   always_comb begin
      next_rdata = `NSR_RST_BYTE;
      if (rd) begin
         unique case (addr)
            `NSR_A_COLL_HI:  next_rdata = {coll_pos[9:8], 6'h00};
            `NSR_A_COLL:     next_rdata = coll_pos[7:0];
            `NSR_A_STRENGTH: next_rdata = {1'b0, osc_ok,
                                           aux_pk, main_pk};
            `NSR_A_OPTIONS:  next_rdata = opts;
            `NSR_A_IRQ_STAT: next_rdata = {5'h00, ist};
            `NSR_A_IRQ_MASK: next_rdata = {5'h00, imask};
            default:         next_rdata = `NSR_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         opts        <= `NSR_RST_BYTE;
         imask       <= 3'h0;
         ist         <= 3'h0;
         pcnt        <= 4'h0;
         coll_detect <= 1'b0;
         osc_ok_d    <= 1'b0;
         rdata       <= `NSR_RST_BYTE;
         irq         <= 1'b0;
      end else begin
         opts        <= next_opts;
         imask       <= next_imask;
         ist         <= next_ist;
         pcnt        <= next_pcnt;
         coll_detect <= next_coll_detect;
         osc_ok_d    <= osc_ok;
         rdata       <= next_rdata;
         irq         <= |(next_ist & next_imask);
      end
   end

   // Option outputs come straight from the option register flops.
   assign typea_parity_disable = opts[`NSR_OPT_PAR];
   assign slot_grid_long       = opts[`NSR_OPT_SLOT];
   assign typea_bitstream_tx   = opts[`NSR_OPT_BITSTR];
   assign four_bit_rx          = opts[`NSR_OPT_FOURB];
   assign normal_framing       = opts[`NSR_OPT_NORMF];
   assign six_pulse_sel        = opts[`NSR_OPT_SIX];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_coll_rd_clr;
      @(posedge clk_sys) disable iff (!reset_n)
      rd && addr == `NSR_A_COLL && !pos_event |=> coll_pos == 10'h000;
   endproperty
   a_coll_rd_clr: assert property (p_coll_rd_clr)
      else $error("collision position not cleared by read");

   property p_coll_cap;
      @(posedge clk_sys) disable iff (!reset_n)
      pos_event && en_q |=> coll_pos[7:0] == $past(pos_in[7:0]);
   endproperty
   a_coll_cap: assert property (p_coll_cap)
      else $error("collision position not captured");

   property p_coll_hi;
      @(posedge clk_sys) disable iff (!reset_n)
      rd && addr == `NSR_A_COLL_HI |=> rdata[7:6] == $past(coll_pos[9:8]);
   endproperty
   a_coll_hi: assert property (p_coll_hi)
      else $error("upper position bits misread");

   property p_osc_time;
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(osc_ok) |-> $past(osc_st) == nsr_pkg::NSR_OSC_WAIT
         && $past(osc_cnt) == 16'(OSC_CYC - 1);
   endproperty
   a_osc_time: assert property (p_osc_time)
      else $error("oscillator ready at wrong time");

   property p_tx_clr;
      @(posedge clk_sys) disable iff (!reset_n)
      tx_start |=> main_pk == 3'h0 && aux_pk == 3'h0;
   endproperty
   a_tx_clr: assert property (p_tx_clr)
      else $error("strength not cleared at transmit");

   property p_peak_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      !rx_active && !amp_meas && !tx_start && en_q
         |=> $stable(main_pk) && $stable(aux_pk);
   endproperty
   a_peak_hold: assert property (p_peak_hold)
      else $error("strength changed outside reception");

   property p_aux_swap;
      @(posedge clk_sys) disable iff (!reset_n)
      rx_active && !amp_meas && !tx_start && en_q && swap_inputs
         |=> aux_pk >= $past(env_one);
   endproperty
   a_aux_swap: assert property (p_aux_swap)
      else $error("auxiliary channel not from swapped input");

   property p_main_dflt;
      @(posedge clk_sys) disable iff (!reset_n)
      rx_active && !amp_meas && !tx_start && en_q && !swap_inputs
         |=> main_pk >= $past(env_one);
   endproperty
   a_main_dflt: assert property (p_main_dflt)
      else $error("main channel not from input one");

   property p_thresh;
      @(posedge clk_sys) disable iff (!reset_n)
      coll_detect |-> pcnt > 4'h5 || $past(bit_end);
   endproperty
   a_thresh: assert property (p_thresh)
      else $error("collision flagged below threshold");

   property p_resv;
      @(posedge clk_sys) disable iff (!reset_n)
      rd && addr == `NSR_A_OPTIONS |=> rdata[7:6] == 2'h0;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved option bits nonzero");

   c_coll_read: cover property (@(posedge clk_sys) disable iff (!reset_n)
      pos_event ##[1:20] rd && addr == `NSR_A_COLL);
   c_osc_ok: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(osc_ok));
   c_coll_det: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(coll_detect) && six_pulse_sel);
endmodule

// *** nsr_bank_tb.sv ***
// Self-checking bench for the status and option register bank.
// Assumes the bank's embedded assertions and a 25 MHz system clock.
`timescale 1ns/100ps
module nsr_bank_tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int OSC_N = 8;      // Short settling count for the run.
   // Addresses read after reset, lowest five bits first.
   localparam logic [34:0] RST_ADDRS = {5'h1f, 5'h1d, 5'h1c, 5'h10,
                                        5'h0f, 5'h0e, 5'h0d};
   logic       clk_sys;
   logic       reset_n;
   logic       enable_pin;
   logic       osc_run_pin;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq;
   logic       pos_event;
   logic [9:0] pos_in;
   logic       typea_mode;
   logic       rx_active;
   logic       tx_start;
   logic       swap_inputs;
   logic       amp_meas;
   logic [2:0] env_one;
   logic [2:0] env_two;
   logic [2:0] car_one;
   logic [2:0] car_two;
   logic       sub_pulse;
   logic       bit_end;
   logic       coll_detect;
   wire  [5:0] opt_out;
   logic [7:0] bv;
   int         miscompares;
   int         n_tests;
   int         cycles;

   // ------------------------------------------------------------
   // Design under test
   // ------------------------------------------------------------
   nsr_bank #(.OSC_CYC(OSC_N)) i_nsr_bank (
      .clk_sys(clk_sys), .reset_n(reset_n), .enable_pin(enable_pin),
      .osc_run_pin(osc_run_pin), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .pos_event(pos_event),
      .pos_in(pos_in), .typea_mode(typea_mode), .rx_active(rx_active),
      .tx_start(tx_start), .swap_inputs(swap_inputs),
      .amp_meas(amp_meas), .env_one(env_one), .env_two(env_two),
      .car_one(car_one), .car_two(car_two), .sub_pulse(sub_pulse),
      .bit_end(bit_end), .coll_detect(coll_detect),
      .typea_parity_disable(opt_out[5]), .slot_grid_long(opt_out[4]),
      .typea_bitstream_tx(opt_out[3]), .four_bit_rx(opt_out[2]),
      .normal_framing(opt_out[1]), .six_pulse_sel(opt_out[0]));

   // Free-running clock, 40 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Cuts a hang short; the full run needs well under a thousand cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Prints the verdict and ends the run.
   task automatic conclude();
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Compares a seen byte with the expected one.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                      input string msg);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask

   // One-cycle write strobe with address and data.
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask

   // One-cycle read strobe; the data stand only in the following cycle.
   task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd   <= 1'b0;
      #1;
      chk(rdata, exp, "register read");
   endtask

   // Position capture pulse.
   task automatic capture(input logic [9:0] p);
      @(posedge clk_sys);
      pos_in    <= p;
      pos_event <= 1'b1;
      @(posedge clk_sys);
      pos_event <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // Start of a reader transmission, which restarts the peak levels.
   task automatic clear_tx();
      @(posedge clk_sys);
      tx_start <= 1'b1;
      @(posedge clk_sys);
      tx_start <= 1'b0;
   endtask

   // A reception or amplitude measurement lasting three cycles.
   task automatic receive(input logic [2:0] e1, input logic [2:0] e2,
                          input logic [2:0] c1, input logic [2:0] c2,
                          input logic amp);
      @(posedge clk_sys);
      env_one   <= e1;
      env_two   <= e2;
      car_one   <= c1;
      car_two   <= c2;
      amp_meas  <= amp;
      rx_active <= ~amp;
      repeat (3) @(posedge clk_sys);
      rx_active <= 1'b0;
      amp_meas  <= 1'b0;
   endtask

   // Subcarrier pulses with a quiet cycle between them.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         sub_pulse <= 1'b1;
         @(posedge clk_sys);
         sub_pulse <= 1'b0;
      end
      #1;
   endtask

   // Bit period boundary, which restarts the pulse count.
   task automatic bit_boundary();
      @(posedge clk_sys);
      bit_end <= 1'b1;
      @(posedge clk_sys);
      bit_end <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n, osc_run_pin, addr, wdata, wr, rd, pos_event} = '0;
      {pos_in, typea_mode, rx_active, tx_start, swap_inputs} = '0;
      {amp_meas, env_one, env_two, car_one, car_two} = '0;
      {sub_pulse, bit_end, miscompares, n_tests, cycles} = '0;
      enable_pin = 1'b1;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      // Reset values, including an unmapped address.
      for (int i = 0; i < 7; i++)
         rd_reg(RST_ADDRS[i*5 +: 5], 8'h00);
      chk({7'h00, irq}, 8'h00, "irq after reset");
      // Each option bit alone; reserved bits stay clear.
      for (int i = 0; i < 6; i++) begin
         bv = 8'h01 << i;
         wr_reg(5'h10, bv | 8'hc0);
         rd_reg(5'h10, bv);
         chk({2'b00, opt_out}, bv, "opt hi");
         chk({2'b00, opt_out}, bv, "opt lo");
      end
      wr_reg(5'h10, 8'h00);
      wr_reg(5'h0f, 8'hff);
      wr_reg(5'h1d, 8'hff);
      rd_reg(5'h1d, 8'h07);
      // Collision position with the two upper bits, then read clear.
      typea_mode <= 1'b1;
      capture(10'h2a5);
      chk({7'h00, irq}, 8'h01, "irq on capture");
      rd_reg(5'h0d, 8'h80);
      rd_reg(5'h0e, 8'ha5);
      rd_reg(5'h0e, 8'h00);
      rd_reg(5'h0d, 8'h00);
      rd_reg(5'h1c, 8'h01);
      @(posedge clk_sys);
      #1;
      chk({7'h00, irq}, 8'h00, "irq after status read");
      typea_mode <= 1'b0;
      capture(10'h3ff);
      rd_reg(5'h0d, 8'h00);
      rd_reg(5'h0e, 8'hff);
      wr_reg(5'h1d, 8'h00);
      capture(10'h011);
      chk({7'h00, irq}, 8'h00, "masked irq");
      rd_reg(5'h1c, 8'h01);
      wr_reg(5'h1d, 8'h07);
      // Anticollision done: the host turns broken-byte framing off.
      wr_reg(5'h10, 8'h02);
      #1;
      chk({7'h00, opt_out[1]}, 8'h01, "normal framing");
      // Peak strength: held, ignored outside reception, cleared by TX.
      receive(3'h3, 3'h5, 3'h0, 3'h0, 1'b0);
      rd_reg(5'h0f, 8'h2b);
      receive(3'h1, 3'h2, 3'h0, 3'h0, 1'b0);
      env_one <= 3'h7;
      rd_reg(5'h0f, 8'h2b);
      clear_tx();
      rd_reg(5'h0f, 8'h00);
      swap_inputs <= 1'b1;
      receive(3'h6, 3'h2, 3'h0, 3'h0, 1'b0);
      rd_reg(5'h0f, 8'h32);
      clear_tx();
      swap_inputs <= 1'b0;
      receive(3'h1, 3'h1, 3'h7, 3'h4, 1'b1);
      rd_reg(5'h0f, 8'h27);
      clear_tx();
      // Pulse thresholds of seven, then six.
      pulses(7);
      chk({7'h00, coll_detect}, 8'h00, "seven pulses");
      pulses(1);
      chk({7'h00, coll_detect}, 8'h01, "eight pulses");
      bit_boundary();
      rd_reg(5'h1c, 8'h02);
      wr_reg(5'h10, 8'h01);
      pulses(6);
      chk({7'h00, coll_detect}, 8'h00, "six pulses");
      pulses(1);
      chk({7'h00, coll_detect}, 8'h01, "seven pulses");
      bit_boundary();
      rd_reg(5'h1c, 8'h02);
      // Oscillator settling.
      osc_run_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_reg(5'h0f, 8'h00);
      repeat (20) @(posedge clk_sys);
      rd_reg(5'h0f, 8'h40);
      rd_reg(5'h1c, 8'h04);
      // Enable low clears the bank like a reset.
      wr_reg(5'h10, 8'h15);
      capture(10'h055);
      enable_pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      enable_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd_reg(5'h10, 8'h00);
      rd_reg(5'h0e, 8'h00);
      rd_reg(5'h1d, 8'h00);
      conclude();
   end
endmodule
